/* File: rtl/cgp_gauge.sv */
/*
 Digital back end of a current gauge: averages the modulator bitstream
 over fixed slots and shows the result as a 1024-level PWM duty cycle.
 Assumes the pulse-density bit and the shutdown pin are asynchronous
 pins; the host measures the duty cycle on pwm_out.
*/
// Functional notes
// - Bitstream is decimated into a signed multi-bit current value per slot.
// - Output is high while the free-running ramp lies below the code.
// - Zero average current gives mid-scale code, half duty.
// - Positive current above half duty, negative below.
// - Full scale gives 95.5 percent, negative full scale 4.5 percent.
// - Current equals 2.2 times duty minus one half, times full scale.
// - Full scale is a fixed build option of 1 A or 10 A.
// - Current is averaged over consecutive 50 ms slots.
// - Ramp and comparator resolve 1024 levels.
// - High time is code plus one half ramp steps.
// - Low shutdown input stops the gauge, high input runs it.
// - One PWM period per slot, nominally 20 Hz.
// - Each period shows the average of the slot just before.
`timescale 1ns/1ps
`include "cgp_map.svh"
module cgp_gauge #(
   parameter int SAMPLE_CYCLES = `CGP_SAMPLE_CYCLES,
   parameter int SUB_BITS = `CGP_SUB_BITS,
   parameter int FULL_SCALE_A = `CGP_FULL_SCALE_A
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic mod_bit_in,
   input wire logic low_power_request_n,
   output logic pwm_out,
   output logic lp_mode,
   output cgp_pkg::cgp_code_t duty_code
);
   import cgp_pkg::*;

   localparam int RB = `CGP_RAMP_BITS;
   localparam int SB = SUB_BITS;
   localparam int CW = RB + SB + 1;
   localparam logic [RB-1:0] GAIN = RB'((`CGP_PWM_LEVELS * `CGP_GAIN_NUM) / `CGP_GAIN_DEN);
   // Samples per slot; compared against twice the ones count to get a signed value
   localparam logic [CW+1:0] TOTAL2 = (CW+2)'(1) << (RB + SB);
   localparam logic [SB-1:0] HALF_SUB = SB'(1) << (SB - 1);
   localparam logic [RB-1:0] RAMP_LAST = '1;
   localparam logic [SB-1:0] SUB_LAST = '1;

   logic mod_bit;
   logic run_req;
   logic tick;
   logic active;
   logic wrap;
   cgp_mode_e mode_reg;
   logic [RB-1:0] ramp_reg;
   logic [SB-1:0] fine_reg;
   logic [CW-1:0] ones_reg;
   logic [CW-1:0] final_count;
   logic signed [CW+1:0] diff;
   logic signed [CW+RB+2:0] prod;
   logic signed [RB:0] offs;
   cgp_code_t code_calc;
   cgp_code_t code_reg;
   logic pwm_reg;

   // Pin inputs pass two flops before use
   cgp_sync #(
      .RESET_VAL(1'b0)
   ) u_sync_bit (
      .clk(clk),
      .rst_n(rst_n),
      .d(mod_bit_in),
      .q(mod_bit)
   );

   cgp_sync #(
      .RESET_VAL(1'b0)
   ) u_sync_sd (
      .clk(clk),
      .rst_n(rst_n),
      .d(low_power_request_n),
      .q(run_req)
   );

   // Mode follows the shutdown input; low means shutdown
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_reg <= CGP_SHUTDOWN;
      end else begin
         case (mode_reg)
            CGP_SHUTDOWN: mode_reg <= run_req ? CGP_RUN : CGP_SHUTDOWN;
            CGP_RUN: mode_reg <= run_req ? CGP_RUN : CGP_SHUTDOWN;
            default: mode_reg <= CGP_SHUTDOWN;
         endcase
      end
   end

   assign active = (mode_reg == CGP_RUN);
   assign lp_mode = !active;

   // Sample enable; held cleared in shutdown so a slot restarts aligned
   cgp_tick_div #(
      .CYCLES(SAMPLE_CYCLES)
   ) u_div (
      .clk(clk),
      .rst_n(rst_n),
      .clear(!active),
      .tick(tick)
   );

   // Last sample of the slot and of the ramp sweep
   assign wrap = tick && (ramp_reg == RAMP_LAST) && (fine_reg == SUB_LAST);

   // Ramp: 1024 levels, each of 2**SB samples, one sweep per slot
   always_ff @(posedge clk) begin
      if (!rst_n || !active) begin
         ramp_reg <= '0;
         fine_reg <= '0;
      end else if (tick) begin
         {ramp_reg, fine_reg} <= {ramp_reg, fine_reg} + 1'b1;
      end
   end

   // Integrate-and-dump of the bitstream over the slot
   always_ff @(posedge clk) begin
      if (!rst_n || !active) begin
         ones_reg <= '0;
      end else if (wrap) begin
         ones_reg <= '0;
      end else if (tick) begin
         ones_reg <= ones_reg + CW'(mod_bit);
      end
   end

   // Signed average and duty mapping: code = mid + avg * 1024 / 2.2
   always_comb begin
      final_count = ones_reg + CW'(mod_bit);
      diff = $signed({1'b0, final_count, 1'b0}) - $signed(TOTAL2);
      prod = diff * $signed({1'b0, GAIN});
      offs = prod[RB+SB+RB -: RB+1];
      code_calc = cgp_code_t'($signed({1'b0, `CGP_MID_CODE}) + offs);
   end

   // Code from the finished slot loads only when a new sweep starts
   always_ff @(posedge clk) begin
      if (!rst_n || !active) begin
         code_reg <= `CGP_MID_CODE;
      end else if (wrap) begin
         code_reg <= code_calc;
      end
   end

   assign duty_code = code_reg;

   // Comparator with a half-step extension at the equal level
   always_ff @(posedge clk) begin
      if (!rst_n || !active) begin
         pwm_reg <= 1'b0;
      end else begin
         pwm_reg <= (ramp_reg < code_reg) ||
            ((ramp_reg == code_reg) && (fine_reg < HALF_SUB));
      end
   end

   assign pwm_out = pwm_reg;

   // Helper: cycles since the last sweep start, for slot length checks
   logic [31:0] gap_cnt;
   logic seen_wrap;
   localparam logic [31:0] SLOT_LAST = 32'(SAMPLE_CYCLES * (1 << (RB + SB)) - 1);

   always_ff @(posedge clk) begin
      if (!rst_n || !active) begin
         gap_cnt <= '0;
         seen_wrap <= 1'b0;
      end else if (wrap) begin
         gap_cnt <= '0;
         seen_wrap <= 1'b1;
      end else begin
         gap_cnt <= gap_cnt + 1'b1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_slot_end;
      active && wrap;
   endsequence

   sequence s_full_pos;
      active && wrap && (final_count == CW'(1 << (RB + SB)));
   endsequence

   sequence s_full_neg;
      active && wrap && (final_count == '0);
   endsequence

   sequence s_zero_avg;
      active && wrap && (final_count == CW'(1 << (RB + SB - 1)));
   endsequence

   a_shutdown_low: assert property (
      !active |=> !pwm_out && (lp_mode == !$past(run_req)))
      else $error("pwm not low in shutdown");

   a_code_hold: assert property (
      active && !wrap && $past(active) |=> $stable(duty_code))
      else $error("duty code changed inside a sweep");

   a_mid_zero: assert property (
      s_zero_avg |=> duty_code == `CGP_MID_CODE)
      else $error("zero average not mid-scale");

   a_full_pos: assert property (
      s_full_pos |=> duty_code == `CGP_FULL_POS_CODE)
      else $error("positive full scale code wrong");

   a_full_neg: assert property (
      s_full_neg |=> duty_code == `CGP_FULL_NEG_CODE)
      else $error("negative full scale code wrong");

   a_sign_side: assert property (
      s_slot_end ##0 (final_count > CW'(1 << (RB + SB - 1))) |=> duty_code > `CGP_MID_CODE)
      else $error("positive current not above mid-scale");

   a_ramp_compare: assert property (
      active && run_req && (ramp_reg < code_reg) |=> pwm_out)
      else $error("pwm low while ramp below code");

   a_ramp_above: assert property (
      active && (ramp_reg > code_reg) |=> !pwm_out)
      else $error("pwm high while ramp above code");

   a_half_step: assert property (
      active && run_req && (ramp_reg == code_reg) |=> pwm_out == ($past(fine_reg) < HALF_SUB))
      else $error("half step extension wrong");

   a_fresh_start: assert property (
      $rose(active) |-> ramp_reg == '0 && fine_reg == '0 && ones_reg == '0 &&
         duty_code == `CGP_MID_CODE)
      else $error("state not cleared on restart");

   a_slot_len: assert property (
      s_slot_end ##0 seen_wrap |-> gap_cnt == SLOT_LAST)
      else $error("slot length wrong");

   a_ramp_step: assert property (
      active && tick && (fine_reg == SUB_LAST) && !wrap |=> ramp_reg == $past(ramp_reg) + 1'b1)
      else $error("ramp did not advance one level");

   a_scale_opt: assert property (
      (FULL_SCALE_A == 1) || (FULL_SCALE_A == 10))
      else $error("full scale option must be 1 or 10");
endmodule

/* File: rtl/cgp_sync.sv */
/*
 Two-flop synchroniser for one asynchronous level.
 Assumes the input is a pin or another clock domain; reset is synchronous.
*/
`timescale 1ns/1ps
module cgp_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic d,
   output logic q
);
   logic meta_reg;

   // First stage is read only by the second stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_reg <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

/* File: rtl/cgp_tick_div.sv */
/*
 Clock divider giving a one-cycle enable pulse every CYCLES clocks.
 Assumes one clock; clear restarts the count at zero.
*/
`timescale 1ns/1ps
module cgp_tick_div #(
   parameter int CYCLES = 305
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   output logic tick
);
   localparam int W = (CYCLES > 2) ? $clog2(CYCLES) : 1;
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   logic [W-1:0] cnt_reg;

   // Pulse on the last count of each period
   assign tick = !clear && (cnt_reg == LAST);

   // Period counter
   always_ff @(posedge clk) begin
      if (!rst_n || clear) begin
         cnt_reg <= '0;
      end else if (cnt_reg == LAST) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end
endmodule

/* File: shared/cgp_map.svh */
/*
 Constants of the current gauge PWM back end: clock rate, slot timing,
 ramp resolution, duty mapping figures and reset values.
 Assumes it is included by bare name after the package is compiled.
*/
`ifndef CGP_MAP_SVH
`define CGP_MAP_SVH

// Clock and slot timing
`define CGP_CLK_PERIOD_NS 10
`define CGP_NS_PER_MS 1000000
`define CGP_SLOT_TIME_MS 50

// Ramp resolution: 1024 levels, each level split into sub-steps
`define CGP_PWM_LEVELS 1024
`define CGP_RAMP_BITS 10
`define CGP_SUB_BITS 4

// Cycles per modulator sample, rounded down so a slot never overruns
`define CGP_SAMPLE_CYCLES ((`CGP_SLOT_TIME_MS * `CGP_NS_PER_MS / `CGP_CLK_PERIOD_NS) / \
   (`CGP_PWM_LEVELS * (1 << `CGP_SUB_BITS)))

// Duty mapping: offset per full scale is levels / 2.2
`define CGP_GAIN_NUM 10
`define CGP_GAIN_DEN 22
`define CGP_MID_CODE 10'h200
`define CGP_FULL_POS_CODE 10'h3d1
`define CGP_FULL_NEG_CODE 10'h02f

// Full scale option in amperes, fixed at build time
`define CGP_FULL_SCALE_A 1

`endif

/* File: shared/cgp_pkg.sv */
/*
 Types of the current gauge PWM back end.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cgp_pkg;

   // Operating mode of the gauge
   typedef enum logic {
      CGP_SHUTDOWN,
      CGP_RUN
   } cgp_mode_e;

   // Duty code, one of 1024 levels
   typedef logic [9:0] cgp_code_t;

endpackage

/* File: sim/cgp_host_meter.sv */
/*
 Host side model: measures high time and period of each PWM sweep
 and turns the duty cycle back into a current in milliamperes.
 Assumes it samples the gauge output on the gauge clock.
*/
`timescale 1ns/1ps
module cgp_host_meter #(
   parameter int FULL_SCALE_A = 1
) (
   input wire logic clk,
   input wire logic pwm_in,
   output int hi_cyc,
   output int per_cyc,
   output int meas_count,
   output real current_ma,
   output real avg_ma
);
   int hi_run = 0;
   int per_run = 1;
   logic pwm_d = 1'b0;

   // Half-step offset removed, then linear duty to current map
   function automatic real to_ma(input int hi, input int per);
      return 2.2 * (real'(hi) / real'(per) - 0.5 - 1.0 / 2048.0) * FULL_SCALE_A * 1000.0;
   endfunction

   // Each rising edge closes one sweep and publishes its figures
   always @(posedge clk) begin
      pwm_d <= pwm_in;
      if (pwm_in && !pwm_d) begin
         hi_cyc <= hi_run;
         per_cyc <= per_run;
         meas_count <= meas_count + 1;
         current_ma <= to_ma(hi_run, per_run);
         // Mean of this reading and the one before damps jitter
         avg_ma <= (to_ma(hi_run, per_run) + current_ma) / 2.0;
         hi_run <= 1;
         per_run <= 1;
      end else begin
         hi_run <= hi_run + (pwm_in ? 1 : 0);
         per_run <= per_run + 1;
      end
   end
endmodule

/* File: sim/test_cgp_gauge.sv */
/*
 Testbench of the gauge back end: reset values, zero, full positive and
 full negative bitstreams and a half-density slot, then a shutdown round trip.
 Assumes the design and the host meter model are compiled first.
*/
`timescale 1ns/1ps
module test_cgp_gauge;
   import cgp_pkg::*;
   localparam int SC = 2;
   localparam int SLOT = 16384 * SC;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic mod_bit_in = 1'b1;
   logic low_power_request_n = 1'b1;
   logic pwm_out;
   logic lp_mode;
   cgp_code_t duty_code;
   int hi_cyc;
   int per_cyc;
   int meas_count;
   real current_ma;
   real avg_ma;
   int err_count = 0;
   int comparisons = 0;

   // 100 MHz clock
   always #5 clk = ~clk;

   cgp_gauge #(.SAMPLE_CYCLES(SC)) uut (
      .clk(clk),
      .rst_n(rst_n),
      .mod_bit_in(mod_bit_in),
      .low_power_request_n(low_power_request_n),
      .pwm_out(pwm_out),
      .lp_mode(lp_mode),
      .duty_code(duty_code)
   );

   cgp_host_meter host (
      .clk(clk),
      .pwm_in(pwm_out),
      .hi_cyc(hi_cyc),
      .per_cyc(per_cyc),
      .meas_count(meas_count),
      .current_ma(current_ma),
      .avg_ma(avg_ma)
   );

   // Exact comparison of a value
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Current comparison, 3 mA tolerance
   task automatic cmp_ma(input real got, input real exp);
      comparisons++;
      if (got > exp + 3.0 || got < exp - 3.0) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, $rtoi(got), $rtoi(exp));
      end
   endtask

   // Waits up to 8 cycles for the mode flag, then checks it
   task automatic wait_lp(input logic v);
      for (int i = 0; i < 8 && lp_mode !== v; i++) @(negedge clk);
      cmp_val(32'(lp_mode), 32'(v));
   endtask

   // Waits for the host to publish a sweep
   task automatic wait_meas();
      int n;
      n = meas_count;
      for (int i = 0; i < SLOT + 100 && meas_count == n; i++) @(negedge clk);
      cmp_val(32'(meas_count != n), 32'h1);
   endtask

   // High time and period of the sweep just ended
   task automatic check_sweep(input int code);
      wait_meas();
      cmp_val(hi_cyc, (code * 16 + 8) * SC);
      cmp_val(per_cyc, SLOT);
   endtask

   // Reset values, then run mode after release
   task automatic test_reset();
      cmp_val(32'(lp_mode), 32'h1);
      cmp_val(32'(pwm_out), 32'h0);
      cmp_val(32'(duty_code), 32'h200);
      rst_n = 1'b1;
      wait_lp(1'b0);
      $display("test reset finished");
   endtask

   // Ones through slot 0, zeros through slot 1, half density in slot 2
   task automatic test_full_scale();
      wait_meas();
      check_sweep(512);
      cmp_ma(current_ma, 0.0);
      cmp_val(32'(duty_code), 32'h3d1);
      mod_bit_in = 1'b0;
      check_sweep(977);
      cmp_ma(current_ma, 1000.0);
      cmp_val(32'(duty_code), 32'h02f);
      // Ones from sample 8192 of slot 2 on, two sync stages included
      repeat (SLOT / 2 - 3) @(negedge clk);
      mod_bit_in = 1'b1;
      check_sweep(47);
      cmp_ma(current_ma, -1000.0);
      cmp_ma(avg_ma, 0.0);
      cmp_val(32'(duty_code), 32'h200);
      $display("test full scale finished");
   endtask

   // Shutdown clears state; leaving it starts a fresh mid-scale sweep
   task automatic test_shutdown();
      int highs;
      highs = 0;
      low_power_request_n = 1'b0;
      mod_bit_in = 1'b1;
      wait_lp(1'b1);
      @(negedge clk);
      cmp_val(32'(duty_code), 32'h200);
      for (int i = 0; i < 20; i++) begin
         @(negedge clk);
         highs += pwm_out;
      end
      cmp_val(highs, 0);
      low_power_request_n = 1'b1;
      wait_lp(1'b0);
      repeat (3) @(negedge clk);
      cmp_val(32'(pwm_out), 32'h1);
      cmp_val(32'(duty_code), 32'h200);
      $display("test shutdown finished");
   endtask

   // Prints the counts and the verdict, then ends the run
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence, inputs change on falling edges
   initial begin
      repeat (12) @(negedge clk);
      test_reset();
      test_full_scale();
      test_shutdown();
      give_verdict();
   end

   // Watchdog, a little beyond three slots and the shutdown round trip
   initial begin
      repeat (3 * SLOT + 2000) @(posedge clk);
      err_count++;
      give_verdict();
   end
endmodule
